// ---- core/exec_pkg.sv ----
// Package with opcode patterns, field positions, widths and reset values of the executor.
package exec_pkg;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W = 13;
    localparam int FILE_DEPTH = 128;
    localparam int LATCH_W = 8;
    // Leading six bits of the two file operations.
    localparam logic [5:0] COMPLEMENT_FILE_OP = 6'h09;
    localparam logic [5:0] DECREMENT_SKIP_ZERO_OP = 6'h0B;
    // Leading three bits of the jump.
    localparam logic [2:0] UNCONDITIONAL_JUMP_OP = 3'h5;
    localparam int OP6_HI = 13;
    localparam int OP6_LO = 8;
    localparam int OP3_LO = 11;
    localparam int DEST_BIT = 7;
    localparam int FADDR_HI = 6;
    localparam int JUMP_HI = 10;
    localparam int LATCH_HI = 4;
    localparam int LATCH_LO = 3;
    localparam logic [DATA_W-1:0] W_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [DATA_W-1:0] ONE = 8'h01;
    localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
    typedef enum logic [1:0] {st_idle, st_exec} exec_state_t;
endpackage

// ---- core/file_ram.sv ----
// File register memory with synchronous write and registered read data.
`timescale 1ns/1ns
module file_ram #(
    parameter int DEPTH = 128,
    parameter int AW    = 7,
    parameter int DW    = 8
) (
    input  wire logic          clk,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data
);
    logic [DW-1:0] mem [DEPTH];

    // Write and read both happen on the clock edge; read data is held in a register.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// ---- core/complement_decskip_jump_exec.sv ----
// Executor for the complement, decrement-and-skip and unconditional jump instructions.
// What this block does
// - Complement op inverts addressed file register.
// - Complement result to W or file by destination.
// - Decrement op subtracts one, wrapping modulo 256.
// - Decrement result to W or file by destination.
// - Zero decrement result discards next instruction as no-op.
// - Skip depends only on new result zero.
// - Jump loads 11-bit immediate into PC low.
// - Jump copies latch bits 4:3 to PC 12:11.
// - Jump takes two cycles, flushing fetched instruction.
// - Jump is unconditional, touches no status or stack.
`timescale 1ns/1ns
module complement_decskip_jump_exec (
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    input  wire logic                         instr_valid,
    input  wire logic [exec_pkg::INSTR_W-1:0] instr,
    input  wire logic [exec_pkg::LATCH_W-1:0] pc_page_latch,
    input  wire logic                         file_load_en,
    input  wire logic [exec_pkg::ADDR_W-1:0]  file_load_addr,
    input  wire logic [exec_pkg::DATA_W-1:0]  file_load_data,
    output logic                              ready,
    output logic                              done,
    output logic                              nop_exec,
    output logic                              flush,
    output logic [exec_pkg::DATA_W-1:0]       w_reg,
    output logic                              zero_flag,
    output logic [exec_pkg::PC_W-1:0]         pc
);
    import exec_pkg::*;

    // Decoding helpers used at acceptance and again at execution.
    function automatic logic is_complement(input logic [INSTR_W-1:0] i);
        return i[OP6_HI:OP6_LO] == COMPLEMENT_FILE_OP;
    endfunction

    function automatic logic is_decrement(input logic [INSTR_W-1:0] i);
        return i[OP6_HI:OP6_LO] == DECREMENT_SKIP_ZERO_OP;
    endfunction

    function automatic logic is_jump(input logic [INSTR_W-1:0] i);
        return i[OP6_HI:OP3_LO] == UNCONDITIONAL_JUMP_OP;
    endfunction

    exec_state_t          state;
    exec_state_t          next_state;
    logic [INSTR_W-1:0]   held;
    logic [INSTR_W-1:0]   next_held;
    logic                 discard;
    logic                 next_discard;
    logic                 next_ready;
    logic                 next_done;
    logic                 next_nop_exec;
    logic                 next_flush;
    logic [DATA_W-1:0]    next_w_reg;
    logic                 next_zero_flag;
    logic [PC_W-1:0]      next_pc;
    logic                 rd_en;
    logic [ADDR_W-1:0]    rd_addr;
    logic [DATA_W-1:0]    rd_data;
    logic                 wr_en;
    logic [ADDR_W-1:0]    wr_addr;
    logic [DATA_W-1:0]    wr_data;
    logic [DATA_W-1:0]    result;
    logic                 accept;

    file_ram #(
        .DEPTH (FILE_DEPTH),
        .AW    (ADDR_W),
        .DW    (DATA_W)
    ) u_file_ram (
        .clk     (clk),
        .rd_en   (rd_en),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data)
    );

    // Result of the held file operation, computed from the registered read data.
    always_comb begin
        if (is_complement(held)) begin
            result = ~rd_data;
        end else begin
            result = rd_data - ONE;
        end
    end

    // Next-state logic for acceptance, execution, flags, program counter and memory.
    always_comb begin
        accept         = instr_valid && (state == st_idle);
        next_state     = state;
        next_held      = held;
        next_discard   = discard;
        next_done      = 1'b0;
        next_nop_exec  = 1'b0;
        next_flush     = 1'b0;
        next_w_reg     = w_reg;
        next_zero_flag = zero_flag;
        next_pc        = pc;
        rd_en          = 1'b0;
        rd_addr        = instr[FADDR_HI:0];
        wr_en          = file_load_en && (state == st_idle);
        wr_addr        = file_load_addr;
        wr_data        = file_load_data;
        case (state)
            st_idle: begin
                if (accept) begin
                    if (discard) begin
                        // The already fetched instruction runs as a no-op.
                        next_discard  = 1'b0;
                        next_nop_exec = 1'b1;
                        next_done     = 1'b1;
                        next_pc       = pc + PC_STEP;
                    end else if (is_jump(instr)) begin
                        // Flags and stack are left alone; no condition is tested.
                        next_pc = {pc_page_latch[LATCH_HI:LATCH_LO],
                                   instr[JUMP_HI:0]};
                        next_discard = 1'b1;
                        next_flush   = 1'b1;
                        next_done    = 1'b1;
                    end else if (is_complement(instr) || is_decrement(instr)) begin
                        rd_en      = 1'b1;
                        next_held  = instr;
                        next_state = st_exec;
                    end else begin
                        next_done = 1'b1;
                        next_pc   = pc + PC_STEP;
                    end
                end
            end
            st_exec: begin
                if (held[DEST_BIT]) begin
                    wr_en   = 1'b1;
                    wr_addr = held[FADDR_HI:0];
                    wr_data = result;
                end else begin
                    next_w_reg = result;
                end
                if (is_complement(held)) begin
                    next_zero_flag = (result == '0);
                end else if (result == '0) begin
                    // Zero flag is not written here even when the result is zero.
                    next_discard = 1'b1;
                    next_flush   = 1'b1;
                end
                next_done  = 1'b1;
                next_pc    = pc + PC_STEP;
                next_state = st_idle;
            end
            default: begin
                next_state = st_idle;
            end
        endcase
        next_ready = (next_state == st_idle);
    end

    // State registers with synchronous reset.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state     <= st_idle;
            held      <= '0;
            discard   <= 1'b0;
            ready     <= 1'b1;
            done      <= 1'b0;
            nop_exec  <= 1'b0;
            flush     <= 1'b0;
            w_reg     <= W_RESET;
            zero_flag <= 1'b0;
            pc        <= PC_RESET;
        end else begin
            state     <= next_state;
            held      <= next_held;
            discard   <= next_discard;
            ready     <= next_ready;
            done      <= next_done;
            nop_exec  <= next_nop_exec;
            flush     <= next_flush;
            w_reg     <= next_w_reg;
            zero_flag <= next_zero_flag;
            pc        <= next_pc;
        end
    end
endmodule

// ---- tb/exec_checker.sv ----
// Concurrent checks on the executor's ports.
`timescale 1ns/1ns
module exec_checker (
    input wire logic                         clk,
    input wire logic                         sys_rst,
    input wire logic                         instr_valid,
    input wire logic [exec_pkg::INSTR_W-1:0] instr,
    input wire logic [exec_pkg::LATCH_W-1:0] pc_page_latch,
    input wire logic                         file_load_en,
    input wire logic [exec_pkg::ADDR_W-1:0]  file_load_addr,
    input wire logic [exec_pkg::DATA_W-1:0]  file_load_data,
    input wire logic                         ready,
    input wire logic                         done,
    input wire logic                         nop_exec,
    input wire logic                         flush,
    input wire logic [exec_pkg::DATA_W-1:0]  w_reg,
    input wire logic                         zero_flag,
    input wire logic [exec_pkg::PC_W-1:0]    pc
);
    import exec_pkg::*;
    logic               pend;
    logic               next_pend;
    logic [INSTR_W-1:0] ti;
    logic [LATCH_W-1:0] tl;
    // A flush leaves a discard pending until the next instruction is taken.
    wire dis = instr_valid & ready & (flush | pend);
    wire tk = instr_valid & ready & !(flush | pend);
    wire jp = tk && instr[13:11] == UNCONDITIONAL_JUMP_OP;
    wire cm = tk && instr[13:8] == COMPLEMENT_FILE_OP;
    wire dc = tk && instr[13:8] == DECREMENT_SKIP_ZERO_OP;
    always_comb next_pend = (instr_valid & ready) ? 1'b0 : (flush | pend);
    // Registers the pending discard and the last offered word and latch.
    always_ff @(posedge clk) begin
        pend <= sys_rst ? 1'b0 : next_pend;
        ti <= instr;
        tl <= pc_page_latch;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_jlo; jp |=> pc[10:0] == ti[10:0]; endproperty
    a_jlo: assert property (p_jlo) else $error("jump low pc wrong");
    property p_jhi; jp |=> pc[12:11] == tl[4:3]; endproperty
    a_jhi: assert property (p_jhi) else $error("jump page bits wrong");
    property p_jfl; jp |=> done && flush && !nop_exec; endproperty
    a_jfl: assert property (p_jfl) else $error("jump no flush");
    property p_jst; jp |=> $stable(zero_flag) && $stable(w_reg); endproperty
    a_jst: assert property (p_jst) else $error("jump changed state");
    property p_nop; dis |=> done && nop_exec && !flush; endproperty
    a_nop: assert property (p_nop) else $error("discard not a no-op");
    property p_cz; cm && !instr[7] |=> !ready ##1 (done && zero_flag == (w_reg == 8'h00));
    endproperty
    a_cz: assert property (p_cz) else $error("complement zero flag wrong");
    property p_cd; cm && instr[7] |=> $stable(w_reg) [*2]; endproperty
    a_cd: assert property (p_cd) else $error("complement to file hit w");
    property p_dz; dc |=> $stable(zero_flag) [*2]; endproperty
    a_dz: assert property (p_dz) else $error("decrement changed flag");
    property p_ds; dc && !instr[7] |=> ##1 (done && flush == (w_reg == 8'h00)); endproperty
    a_ds: assert property (p_ds) else $error("skip decision wrong");
    c_jump: cover property (jp);
    c_disc: cover property (dis);
    c_dec: cover property (dc && !instr[7]);
endmodule

bind complement_decskip_jump_exec exec_checker i_exec_checker (.clk(clk), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr(instr), .pc_page_latch(pc_page_latch),
    .file_load_en(file_load_en), .file_load_addr(file_load_addr),
    .file_load_data(file_load_data), .ready(ready), .done(done), .nop_exec(nop_exec),
    .flush(flush), .w_reg(w_reg), .zero_flag(zero_flag), .pc(pc));

// ---- tb/testbench.sv ----
// Directed testbench for the executor.
`timescale 1ns/1ns
module testbench;
    import exec_pkg::*;
    logic               clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic               instr_valid = 1'b0;
    logic [INSTR_W-1:0] instr = 14'h0000;
    logic [LATCH_W-1:0] pc_page_latch = 8'h00;
    logic               file_load_en = 1'b0;
    logic [ADDR_W-1:0]  file_load_addr = 7'h00;
    logic [DATA_W-1:0]  file_load_data = 8'h00;
    logic               ready, done, nop_exec, flush, zero_flag;
    logic [DATA_W-1:0]  w_reg;
    logic [PC_W-1:0]    pc;
    int                 err_count = 0;
    int                 checks = 0;
    int                 cyc = 0;
    complement_decskip_jump_exec i_complement_decskip_jump_exec (.clk(clk), .sys_rst(sys_rst),
        .instr_valid(instr_valid), .instr(instr), .pc_page_latch(pc_page_latch),
        .file_load_en(file_load_en), .file_load_addr(file_load_addr),
        .file_load_data(file_load_data), .ready(ready), .done(done), .nop_exec(nop_exec),
        .flush(flush), .w_reg(w_reg), .zero_flag(zero_flag), .pc(pc));
    // Clock with a 100 ns period.
    initial begin
        forever #50 clk = ~clk;
    end
    // Cycle ceiling that cuts a hang short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [PC_W-1:0] seen, input logic [PC_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Preloads one file register while the block is idle.
    task automatic load(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        file_load_en <= 1'b1;
        file_load_addr <= a;
        file_load_data <= d;
        @(posedge clk);
        file_load_en <= 1'b0;
    endtask
    // Offers one word, holds it until taken, then returns in the done cycle.
    task automatic issue(input logic [INSTR_W-1:0] i);
        int n;
        n = 0;
        @(posedge clk);
        instr <= i;
        instr_valid <= 1'b1;
        do @(negedge clk); while (ready !== 1'b1);
        @(posedge clk);
        instr_valid <= 1'b0;
        do begin @(negedge clk); n++; end while (done !== 1'b1 && n < 4);
        chk("done", done, 1'b1);
    endtask
    // Complement of address 127 into W, then of address 6 into the file with a zero result, then back into W.
    task automatic t_comp();
        load(7'h7F, 8'h13);
        issue(14'h097F);
        chk("w", w_reg, 8'hEC);
        chk("z", zero_flag, 1'b0);
        load(7'h06, 8'hFF);
        issue(14'h0986);
        chk("z", zero_flag, 1'b1);
        issue(14'h0906);
        chk("w", w_reg, 8'hFF);
    endtask
    // Zero flag set first, so a decrement that touched it would show.
    // Skip on a zero W result, the discarded word, a wrapping decrement, a skip to file.
    task automatic t_dec();
        load(7'h05, 8'hFF);
        issue(14'h0985);
        chk("z", zero_flag, 1'b1);
        load(7'h07, 8'h01);
        issue(14'h0B07);
        chk("w", w_reg, 8'h00);
        chk("flush", flush, 1'b1);
        chk("z", zero_flag, 1'b1);
        issue(14'h0907);
        chk("nop", nop_exec, 1'b1);
        chk("w", w_reg, 8'h00);
        chk("z", zero_flag, 1'b1);
        issue(14'h0B86);
        chk("flush", flush, 1'b0);
        issue(14'h0B06);
        chk("w", w_reg, 8'hFE);
        issue(14'h0B87);
        chk("flush", flush, 1'b1);
        chk("w", w_reg, 8'hFE);
        issue(14'h0B06);
        chk("nop", nop_exec, 1'b1);
        chk("w", w_reg, 8'hFE);
    endtask
    // Jumps with both page bits set and clear, and the flushed next word.
    task automatic t_jump();
        @(posedge clk);
        pc_page_latch <= 8'h18;
        issue(14'h2ABC);
        chk("pc", pc, 13'h1ABC);
        chk("flush", flush, 1'b1);
        issue(14'h097F);
        chk("nop", nop_exec, 1'b1);
        chk("pc", pc, 13'h1ABD);
        @(posedge clk);
        pc_page_latch <= 8'hE7;
        issue(14'h2FFF);
        chk("pc", pc, 13'h07FF);
        chk("z", zero_flag, 1'b1);
        chk("w", w_reg, 8'hFE);
        issue(14'h0000);
        chk("nop", nop_exec, 1'b1);
        issue(14'h0000);
        chk("nop", nop_exec, 1'b0);
        chk("pc", pc, 13'h0801);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_comp();
        t_dec();
        t_jump();
        give_verdict();
    end
endmodule
